// >>> shared/qdl_pkg.sv
// Package: constants, offsets and types for the quad converter serial loader.
package qdl_pkg;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 10;
   localparam int unsigned SHIFT_BITS = 11;
   localparam int unsigned CODE_BITS = 8;
   localparam int unsigned CHANNELS = 4;
   localparam int unsigned CHAN_HI_POS = 9;
   localparam int unsigned CHAN_LO_POS = 8;
   localparam logic [10:0] SHIFT_RST = 11'h000;
   localparam logic [7:0] CODE_RST = 8'h00;

   // ------------------------------------------------------------
   // Pin indices in the synchroniser bundle
   // ------------------------------------------------------------
   localparam int unsigned PIN_SCL = 0;
   localparam int unsigned PIN_SDA = 1;
   localparam int unsigned PIN_LOAD = 2;
   localparam int unsigned PIN_UPD = 3;
   localparam int unsigned PIN_FLT = 4;
   localparam int unsigned NUM_PINS = 5;
   // Idle levels: clock, data and both strobes high, load pin driven.
   localparam logic [4:0] PIN_RST = 5'h0f;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_INPUT = 8'h08;
   localparam logic [7:0] OFF_OUTPUT = 8'h0c;

   localparam int unsigned CTRL_LINK_EN = 0;
   localparam int unsigned CTRL_SW_UPD = 1;
   localparam logic CTRL_LINK_EN_RST = 1'b1;

   localparam int unsigned ST_TWO_WIRE = 0;
   localparam int unsigned ST_IN_FRAME = 1;
   localparam int unsigned ST_ARMED = 2;
   localparam int unsigned ST_BITS_LSB = 4;
   localparam int unsigned ST_LOADS_LSB = 8;
   localparam int unsigned ST_CHAN_LSB = 16;
   localparam logic [3:0] BITS_RST = 4'h0;
   localparam logic [7:0] LOADS_RST = 8'h00;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;

   // ------------------------------------------------------------
   // Two-wire frame tracker
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TW_IDLE,
      TW_ARMED,
      TW_FRAME
   } qdl_tw_e;

endpackage

// >>> shared/qdl_pins_if.sv
// Interface: synchronised pin levels and their previous samples.
`timescale 1ns/10ps
interface qdl_pins_if;
   logic [4:0] lvl;
   logic [4:0] prev;

   modport src (
      output lvl,
      output prev
   );

   modport dst (
      input lvl,
      input prev
   );
endinterface

// >>> design/qdl_pin_sync.sv
// Module: two-flop synchronisers plus one history stage for the serial pins.
`timescale 1ns/10ps
module qdl_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] pins_raw,
   qdl_pins_if.src pins
);

   logic [4:0] meta;
   logic [4:0] stable;
   logic [4:0] hist;

   // ------------------------------------------------------------
   // Synchroniser
   // ------------------------------------------------------------
   // The first stage is read only by the second one; edges are found
   // between the second and third stages.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= qdl_pkg::PIN_RST;
         stable <= qdl_pkg::PIN_RST;
         hist <= qdl_pkg::PIN_RST;
      end else begin
         meta <= pins_raw;
         stable <= meta;
         hist <= stable;
      end
   end

   assign pins.lvl = stable;
   assign pins.prev = hist;

endmodule // qdl_pin_sync

// >>> design/qdl_top.sv
// Module: serial loader of a quad 8-bit converter with an APB register view.
//
// Contract
// - Floating load pin selects 2-wire, driven high 3-wire.
// - 3-wire samples data on clock fall, 10 bits.
// - Channel bits first, then code MSB to LSB.
// - Channel bits pick input register A to D.
// - Load low, clock high, update high loads register.
// - Update low copies all input registers to outputs.
// - Bits leaving the shift register drive chain output.
// - Start is data fall, then clock fall.
// - Start shifts a zero; register grows to 11.
// - Stop is data low, clock rise, data rise.
`timescale 1ns/10ps
module qdl_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_data,
   input wire logic shift_clock,
   input wire logic frame_load_n,
   input wire logic frame_load_float,
   input wire logic output_update_strobe_n,
   output logic serial_chain_out,
   output logic [31:0] dac_codes
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   typedef logic [7:0] qdl_code_t [4];

   // Packs four codes with channel A in the lowest byte.
   function automatic logic [31:0] qdl_pack(input qdl_code_t codes);
      logic [31:0] word;
      word = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         word[i*8 +: 8] = codes[i];
      end
      return word;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   qdl_pins_if pins ();

   wire logic [4:0] pins_raw;

   assign pins_raw[qdl_pkg::PIN_SCL] = shift_clock;
   assign pins_raw[qdl_pkg::PIN_SDA] = serial_data;
   assign pins_raw[qdl_pkg::PIN_LOAD] = frame_load_n;
   assign pins_raw[qdl_pkg::PIN_UPD] = output_update_strobe_n;
   assign pins_raw[qdl_pkg::PIN_FLT] = frame_load_float;

   qdl_pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins_raw(pins_raw),
      .pins(pins.src)
   );

   // ------------------------------------------------------------
   // Pin levels and edges
   // ------------------------------------------------------------
   wire logic scl_now;
   wire logic scl_was;
   wire logic sda_now;
   wire logic sda_was;
   wire logic load_now;
   wire logic upd_now;
   wire logic two_wire;
   wire logic scl_fall;
   wire logic sda_fall;
   wire logic sda_rise;
   wire logic scl_held_high;

   assign scl_now = pins.lvl[qdl_pkg::PIN_SCL];
   assign scl_was = pins.prev[qdl_pkg::PIN_SCL];
   assign sda_now = pins.lvl[qdl_pkg::PIN_SDA];
   assign sda_was = pins.prev[qdl_pkg::PIN_SDA];
   assign load_now = pins.lvl[qdl_pkg::PIN_LOAD];
   assign upd_now = pins.lvl[qdl_pkg::PIN_UPD];
   // The pad reports a floating load pin; its pull-up would read high.
   assign two_wire = pins.lvl[qdl_pkg::PIN_FLT];
   assign scl_fall = scl_was & ~scl_now;
   assign sda_fall = sda_was & ~sda_now;
   assign sda_rise = ~sda_was & sda_now;
   assign scl_held_high = scl_was & scl_now;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic link_en;
   logic sw_update;
   logic [10:0] shreg;
   logic [3:0] bit_count;
   logic [7:0] load_count;
   logic [1:0] last_chan;
   logic load_seen;
   qdl_code_t in_reg;
   qdl_code_t out_reg;
   qdl_pkg::qdl_tw_e tw_state;
   qdl_pkg::qdl_tw_e next_tw_state;

   // ------------------------------------------------------------
   // Two-wire start and stop detection
   // ------------------------------------------------------------
   wire logic tw_active;
   wire logic start_arm;
   wire logic start_take;
   wire logic stop_seen;

   assign tw_active = link_en & two_wire;
   // Data falling while the clock stays high arms a start.
   assign start_arm = tw_active & sda_fall & scl_held_high;
   // The clock falling with data low completes the start.
   assign start_take = tw_active & (tw_state == qdl_pkg::TW_ARMED) &
                       scl_fall & ~sda_was;
   // Data rising while the clock stays high ends the frame.
   assign stop_seen = tw_active & (tw_state == qdl_pkg::TW_FRAME) &
                      sda_rise & scl_held_high;

   always_comb begin
      next_tw_state = tw_state;
      unique case (tw_state)
         qdl_pkg::TW_IDLE: begin
            if (start_arm) begin
               next_tw_state = qdl_pkg::TW_ARMED;
            end
         end
         qdl_pkg::TW_ARMED: begin
            if (start_take) begin
               next_tw_state = qdl_pkg::TW_FRAME;
            end else if (sda_rise & scl_held_high) begin
               next_tw_state = qdl_pkg::TW_IDLE;
            end
         end
         qdl_pkg::TW_FRAME: begin
            // A data fall with the clock high retriggers a start.
            if (stop_seen) begin
               next_tw_state = qdl_pkg::TW_IDLE;
            end else if (start_arm) begin
               next_tw_state = qdl_pkg::TW_ARMED;
            end
         end
      endcase
      if (!tw_active) begin
         next_tw_state = qdl_pkg::TW_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tw_state <= qdl_pkg::TW_IDLE;
      end else begin
         tw_state <= next_tw_state;
      end
   end

   // ------------------------------------------------------------
   // Shift register
   // ------------------------------------------------------------
   wire logic shift_3w;
   wire logic shift_2w;
   wire logic shift_evt;
   wire logic shift_bit;
   wire logic leaving_bit;

   // The level just before the fall is used, so data may move
   // as soon as the clock is low.
   assign shift_3w = link_en & ~two_wire & scl_fall;
   assign shift_2w = start_take |
                     (tw_active & (tw_state == qdl_pkg::TW_FRAME) & scl_fall);
   assign shift_evt = shift_3w | shift_2w;
   assign shift_bit = start_take ? 1'b0 : sda_was;
   // The 3-wire path is ten stages, the 2-wire path eleven.
   assign leaving_bit = two_wire ? shreg[qdl_pkg::SHIFT_BITS-1]
                                 : shreg[qdl_pkg::FRAME_BITS-1];

   // First bit ends up at the top, so the frame arrives MSB first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg <= qdl_pkg::SHIFT_RST;
      end else if (shift_evt) begin
         shreg <= {shreg[9:0], shift_bit};
      end
   end

   // Chain output changes only when a bit leaves, like a real stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_chain_out <= 1'b0;
      end else if (shift_evt) begin
         serial_chain_out <= leaving_bit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_count <= qdl_pkg::BITS_RST;
      end else if (start_take || stop_seen) begin
         bit_count <= qdl_pkg::BITS_RST;
      end else if (shift_evt && bit_count != 4'hf) begin
         bit_count <= bit_count + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Input registers
   // ------------------------------------------------------------
   wire logic load_3w;
   wire logic load_evt;
   wire logic [1:0] frame_chan;
   wire logic [7:0] frame_code;

   assign load_3w = link_en & ~two_wire & ~load_now & scl_now & upd_now;
   assign load_evt = load_3w | stop_seen;
   assign frame_chan = {shreg[qdl_pkg::CHAN_HI_POS], shreg[qdl_pkg::CHAN_LO_POS]};
   assign frame_code = shreg[qdl_pkg::CODE_BITS-1:0];

   // Channel bits 00, 01, 10 and 11 address A, B, C and D.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            in_reg[i] <= qdl_pkg::CODE_RST;
         end
      end else if (load_evt) begin
         in_reg[frame_chan] <= frame_code;
      end
   end

   // A held 3-wire load counts once, on its first cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_seen <= 1'b0;
         load_count <= qdl_pkg::LOADS_RST;
         last_chan <= 2'h0;
      end else begin
         load_seen <= load_evt;
         if (load_evt && !load_seen) begin
            load_count <= load_count + 8'h01;
            last_chan <= frame_chan;
         end
      end
   end

   // ------------------------------------------------------------
   // Output code registers
   // ------------------------------------------------------------
   wire logic update_all;

   // The strobe is level sensitive: outputs follow the inputs while low.
   assign update_all = ~upd_now | sw_update;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            out_reg[i] <= qdl_pkg::CODE_RST;
         end
      end else if (update_all) begin
         out_reg <= in_reg;
      end
   end

   assign dac_codes = qdl_pack(out_reg);

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   wire logic setup_phase;
   wire logic access_phase;
   wire logic addr_hit;
   wire logic wr_ctrl;
   wire logic [31:0] ctrl_word;
   wire logic [31:0] status_word;
   wire logic [31:0] rd_mux;

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign addr_hit = (paddr == qdl_pkg::OFF_CTRL) | (paddr == qdl_pkg::OFF_STATUS) |
                     (paddr == qdl_pkg::OFF_INPUT) | (paddr == qdl_pkg::OFF_OUTPUT);
   // Read data is registered in setup, so every access ends at once.
   assign pready = access_phase;
   assign pslverr = access_phase & ~addr_hit;
   assign wr_ctrl = access_phase & pwrite & pstrb[0] & (paddr == qdl_pkg::OFF_CTRL);

   assign ctrl_word = {31'h0000_0000, link_en};

   assign status_word = {14'h0000, last_chan, load_count, bit_count, 1'b0,
                         tw_state == qdl_pkg::TW_ARMED,
                         tw_state == qdl_pkg::TW_FRAME, two_wire};

   assign rd_mux = (paddr == qdl_pkg::OFF_CTRL) ? ctrl_word :
                   (paddr == qdl_pkg::OFF_STATUS) ? status_word :
                   (paddr == qdl_pkg::OFF_INPUT) ? qdl_pack(in_reg) :
                   (paddr == qdl_pkg::OFF_OUTPUT) ? qdl_pack(out_reg) :
                   qdl_pkg::DATA_RST;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= qdl_pkg::DATA_RST;
      end else if (setup_phase && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Software update is a one-cycle pulse; the bit never reads back.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_en <= qdl_pkg::CTRL_LINK_EN_RST;
         sw_update <= 1'b0;
      end else begin
         sw_update <= wr_ctrl & pwdata[qdl_pkg::CTRL_SW_UPD];
         if (wr_ctrl) begin
            link_en <= pwdata[qdl_pkg::CTRL_LINK_EN];
         end
      end
   end

endmodule // qdl_top

// >>> dv/qdl_top_properties.sv
// Checker: port-level properties of the quad converter serial loader.
`timescale 1ns/10ps
module qdl_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_data,
   input wire logic shift_clock,
   input wire logic frame_load_n,
   input wire logic frame_load_float,
   input wire logic output_update_strobe_n,
   input wire logic serial_chain_out,
   input wire logic [31:0] dac_codes
);
   // Ages count cycles since the last legal cause of a change; they saturate at 15.
   logic [3:0] upd_age;
   logic [3:0] fall_age;
   logic scl_d;
   wire unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h0c);
   wire sw_upd = psel && penable && pwrite && paddr == 8'h00 && pwdata[1] && pstrb[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_age <= 4'hf;
         fall_age <= 4'hf;
         scl_d <= 1'b1;
      end else begin
         scl_d <= shift_clock;
         upd_age <= (!output_update_strobe_n || sw_upd) ? 4'h0 : upd_age + {3'h0, upd_age != 4'hf};
         fall_age <= (scl_d && !shift_clock) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd_at(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   property p_ready;
      pready == (psel && penable);
   endproperty
   a_ready: assert property (p_ready) else $error("pready differs from access phase");
   property p_err_cause;
      pslverr |-> psel && penable && unmapped;
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("pslverr without unmapped access");
   property p_err_unmapped;
      s_access ##0 unmapped |-> pslverr;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
   property p_unmapped_zero;
      psel && !penable && !pwrite && unmapped ##1 s_access |-> prdata == 32'h0000_0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_prdata_hold;
      !$past(psel && !penable && !pwrite) |-> $stable(prdata);
   endproperty
   a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved without read");
   property p_output_mirror;
      s_rd_at(8'h0c) ##1 s_access |-> prdata == $past(dac_codes);
   endproperty
   a_output_mirror: assert property (p_output_mirror) else $error("output view wrong");
   property p_dac_cause;
      $changed(dac_codes) |-> upd_age <= 4'h6;
   endproperty
   a_dac_cause: assert property (p_dac_cause) else $error("codes moved without update");
   property p_chain_cause;
      $changed(serial_chain_out) |-> fall_age <= 4'h6;
   endproperty
   a_chain_cause: assert property (p_chain_cause) else $error("chain out moved unshifted");
endmodule // qdl_chk
bind qdl_top qdl_chk u_qdl_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serial_data(serial_data), .shift_clock(shift_clock),
   .frame_load_n(frame_load_n), .frame_load_float(frame_load_float),
   .output_update_strobe_n(output_update_strobe_n), .serial_chain_out(serial_chain_out),
   .dac_codes(dac_codes));

// >>> dv/qdl_host_model.sv
// Partner: host controller driving the serial pins of the converter loader.
`timescale 1ns/10ps
module qdl_host_model (
   output logic sda,
   output logic scl,
   output logic load_n,
   output logic flt,
   output logic upd_n
);
   logic tw = 1'b0;
   initial begin
      sda = 1'b1;
      scl = 1'b1;
      load_n = 1'b1;
      flt = 1'b0;
      upd_n = 1'b1;
   end
   // The 7 ns step keeps pin changes off the bench clock edges.
   task automatic bit_out(input logic b);
      #7;
      sda = b;
      if (tw) begin
         #80 scl = 1'b1;
         #160 scl = 1'b0;
         #80;
      end else begin
         #160 scl = 1'b0;
         #160 scl = 1'b1;
      end
   endtask
   task automatic frame(input logic [9:0] v);
      for (int i = 9; i >= 0; i--) begin
         bit_out(v[i]);
      end
   endtask
   task automatic load3();
      load_n = 1'b0;
      #160 load_n = 1'b1;
      sda = ~sda;
      #160;
   endtask
   task automatic update();
      #7;
      upd_n = 1'b0;
      #160 upd_n = 1'b1;
      #160;
   endtask
   task automatic start2();
      tw = 1'b1;
      flt = 1'b1;
      sda = 1'b1;
      // One device only: these margins already cover a single chain delay.
      #320 sda = 1'b0;
      #160 scl = 1'b0;
      #80;
   endtask
   task automatic stop2();
      sda = 1'b0;
      #80 scl = 1'b1;
      #160 sda = 1'b1;
      #400;
   endtask
   // Drives the load pin to a firm high again, back to 3-wire mode.
   task automatic mode3();
      #7;
      tw = 1'b0;
      flt = 1'b0;
   endtask
endmodule // qdl_host_model

// >>> dv/tb_top.sv
// Testbench: APB and serial-link scenarios for the quad converter serial loader.
`timescale 1ns/10ps
module tb_top;
   typedef struct {
      string name;
      int sel;
      logic [31:0] exp;
   } qdl_note_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sd;
   logic sc;
   logic ld_n;
   logic flt;
   logic upd_n;
   logic chain;
   logic [31:0] dac;
   logic [31:0] rnd = 32'h8f76_8407;
   logic [31:0] exp_in = 32'h0000_0000;
   logic [9:0] f1;
   qdl_note_s notes[$];
   qdl_note_s cur;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   event chk_ev;
   always #20 pclk = ~pclk;
   qdl_top u_qdl_top (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_data(sd), .shift_clock(sc), .frame_load_n(ld_n),
      .frame_load_float(flt), .output_update_strobe_n(upd_n), .serial_chain_out(chain),
      .dac_codes(dac)
   );
   qdl_host_model u_qdl_host_model (
      .sda(sd), .scl(sc), .load_n(ld_n), .flt(flt), .upd_n(upd_n)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic note(input string name, input int sel, input logic [31:0] exp);
      notes.push_back('{name, sel, exp});
      ->chk_ev;
   endtask
   // Read data and error are noted at the edge that samples pready, before they move.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] exp_rd, input logic exp_err);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      if (!w) note("prdata", 0, exp_rd);
      note("pslverr", 1, {31'h0, exp_err});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(chk_ev) begin
      while (notes.size() > 0) begin
         cur = notes.pop_front();
         case (cur.sel)
            0: check(cur.name, prdata, cur.exp);
            1: check(cur.name, {31'h0, pslverr}, cur.exp);
            2: check(cur.name, dac, cur.exp);
            default: check(cur.name, {31'h0, chain}, cur.exp);
         endcase
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(8'h00, 1'b0, 32'h0, 32'h0000_0001, 1'b0);
      apb(8'h04, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
      apb(8'h12, 1'b0, 32'h0, 32'h0000_0000, 1'b1);
      for (int ch = 0; ch < 4; ch++) begin
         rnd = lfsr(rnd);
         exp_in[ch*8 +: 8] = rnd[7:0];
         u_qdl_host_model.frame({ch[1:0], rnd[7:0]});
         u_qdl_host_model.load3();
      end
      apb(8'h08, 1'b0, 32'h0, exp_in, 1'b0);
      note("dac_codes", 2, 32'h0000_0000);
      u_qdl_host_model.update();
      note("dac_codes", 2, exp_in);
      apb(8'h0c, 1'b0, 32'h0, exp_in, 1'b0);
      rnd = lfsr(rnd);
      f1 = rnd[9:0];
      rnd = lfsr(rnd);
      u_qdl_host_model.frame(f1);
      for (int k = 9; k >= 0; k--) begin
         u_qdl_host_model.bit_out(rnd[k]);
         #80;
         note("chain_out", 3, {31'h0, f1[k]});
      end
      rnd = lfsr(rnd);
      u_qdl_host_model.start2();
      u_qdl_host_model.frame(~rnd[9:0]);
      u_qdl_host_model.bit_out(1'b0);
      u_qdl_host_model.frame(rnd[9:0]);
      u_qdl_host_model.stop2();
      exp_in[8*int'(rnd[9:8]) +: 8] = rnd[7:0];
      apb(8'h08, 1'b0, 32'h0, exp_in, 1'b0);
      apb(8'h04, 1'b0, 32'h0, {14'h0, rnd[9:8], 8'h05, 8'h01}, 1'b0);
      apb(8'h00, 1'b1, 32'h0000_0000, 32'h0, 1'b0);
      apb(8'h00, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
      u_qdl_host_model.mode3();
      u_qdl_host_model.frame({2'b00, ~exp_in[7:0]});
      u_qdl_host_model.load3();
      apb(8'h08, 1'b0, 32'h0, exp_in, 1'b0);
      apb(8'h00, 1'b1, 32'h0000_0003, 32'h0, 1'b0);
      repeat (4) @(posedge pclk);
      note("dac_codes", 2, exp_in);
      end_of_test();
   end
endmodule // tb_top
